// >>> rtl/apms_map.vh
// constants for the converter power-management sequencer
// Function
// [R1] mode bits plus sleep pin choose behaviour
// [R2] full down kills all; partial keeps reference
// [R3] host sets mode zero for pin control
// [R4] mode zero: pin high up, low sleeps between
// [R5] codes 01,10,11 select software power modes
// [R6] first strobe starts timeout then self calibration; here calibration waits for the next strobe rise after timeout
// [R7] sleep pin ignored until calibration ends
// [R8] early control write skips timeout and calibration
// [R9] host waits 300 us before manual calibration
// [R10] wake from full power-down takes 5 us
// [R11] host limits rate when sleeping between conversions
// [R12] conversion end powers down in between modes
// [R13] strobe falling edge wakes the device
// [R14] host holds strobe low at least 5 us
// [R15] host may power up by write, then convert
// [R16] timeout and calibration each last 32 ms
// [R17] strobes ignored while timeout busy is high
// [R18] code 10 stays down until code rewritten
`ifndef APMS_MAP_VH
`define APMS_MAP_VH
`define APMS_CLK_HZ       25000000
`define APMS_TIMEOUT_US   32000
`define APMS_WAKE_US      5
`define APMS_TIMEOUT_CYC  ((`APMS_TIMEOUT_US * (`APMS_CLK_HZ / 1000)) / 1000)
`define APMS_WAKE_CYC     ((`APMS_WAKE_US * (`APMS_CLK_HZ / 1000)) / 1000)
`define APMS_CONV_CYC     115
`define APMS_MODE_PIN     2'h0
`define APMS_MODE_BETWEEN 2'h1
`define APMS_MODE_DOWN    2'h2
`define APMS_MODE_PARTIAL 2'h3
`endif

// >>> rtl/apms_sync2.v
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module apms_sync2 #(
  parameter RESET_VAL = 1'b0
) (
  input  wire ref_clk,
  input  wire rstn,
  input  wire din,
  output reg  dout_ff
);
  reg meta_ff;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= RESET_VAL;
      dout_ff <= RESET_VAL;
    end else begin
      meta_ff <= din;
      dout_ff <= meta_ff;
    end
  end
endmodule // apms_sync2

// >>> rtl/apms_sequencer.v
// power-management sequencer for a multi-channel sampling converter
`timescale 1ns/1ps
`include "apms_map.vh"
module apms_sequencer #(
  parameter TIMEOUT_CYC = `APMS_TIMEOUT_CYC,
  parameter WAKE_CYC    = `APMS_WAKE_CYC,
  parameter CONV_CYC    = `APMS_CONV_CYC
) (
  input  wire       ref_clk,
  input  wire       rstn,
  input  wire       conversion_start_strobe_n,
  input  wire       sleep_n,
  input  wire       ctrl_wr,
  input  wire       power_mode_hi_bit,
  input  wire       power_mode_lo_bit,
  output reg        busy_ff,
  output reg        core_on_ff,
  output reg        ref_on_ff,
  output reg        cal_run_ff,
  output reg        cal_done_ff,
  output reg        conv_run_ff
);
  localparam ST_INIT    = 3'h0;
  localparam ST_TIMEOUT = 3'h1;
  localparam ST_WAITCAL = 3'h2;
  localparam ST_CAL     = 3'h3;
  localparam ST_IDLE    = 3'h4;
  localparam ST_WAKE    = 3'h5;
  localparam ST_CONV    = 3'h6;
  localparam ST_DOWN    = 3'h7;

  wire       strobe_s;
  wire       sleep_s;
  reg        strobe_d_ff;
  reg  [2:0] state_ff;
  reg  [2:0] nxt_state;
  reg  [1:0] mode_ff;
  reg  [1:0] nxt_mode;
  reg        strobe_seen_ff;
  reg  [20:0] cnt_ff;
  reg  [20:0] nxt_cnt;
  reg        wake_done_ff;
  reg        nxt_wake_done;
  reg        nxt_busy;
  reg        nxt_core;
  reg        nxt_ref;
  reg        nxt_cal_run;
  reg        nxt_cal_done;
  reg        nxt_conv;
  reg        sleep_between;
  reg        pin_sleep;

  apms_sync2 #(.RESET_VAL(1'b1)) u_sync_strobe (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     (conversion_start_strobe_n),
    .dout_ff (strobe_s)
  );

  apms_sync2 #(.RESET_VAL(1'b1)) u_sync_sleep (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     (sleep_n),
    .dout_ff (sleep_s)
  );

  // edge detector resets to the idle-high level so reset gives no false edge
  wire strobe_fall = strobe_d_ff & ~strobe_s;
  wire strobe_rise = ~strobe_d_ff & strobe_s;
  wire cnt_zero    = (cnt_ff == 21'h0);

  always @* begin
    nxt_state     = state_ff;
    nxt_mode      = mode_ff;
    nxt_cnt       = cnt_zero ? cnt_ff : cnt_ff - 21'h1;
    nxt_wake_done = wake_done_ff;
    nxt_cal_done  = cal_done_ff;
    if (ctrl_wr) begin
      nxt_mode = {power_mode_hi_bit, power_mode_lo_bit}; // R1
    end
    pin_sleep     = (nxt_mode == `APMS_MODE_PIN) & ~sleep_s; // R4
    sleep_between = pin_sleep | (nxt_mode == `APMS_MODE_BETWEEN) |
                    (nxt_mode == `APMS_MODE_PARTIAL); // R5
    case (state_ff)
      // power-on: first strobe or an early control write decides
      ST_INIT: begin
        if (ctrl_wr & ~strobe_seen_ff) begin
          nxt_state    = ST_IDLE; // R8
          nxt_cal_done = 1'b1;
        end else if (strobe_rise) begin
          nxt_state = ST_TIMEOUT; // R6
          nxt_cnt   = TIMEOUT_CYC[20:0]; // R16
        end
      end

      // further strobes ignored until the count runs out
      ST_TIMEOUT: begin
        if (cnt_zero) begin
          nxt_state = ST_WAITCAL; // R17
        end
      end

      // next strobe rise starts the self calibration
      ST_WAITCAL: begin
        if (strobe_rise) begin
          nxt_state = ST_CAL;
          nxt_cnt   = TIMEOUT_CYC[20:0]; // R16
        end
      end

      // calibration lasts as long as the timeout
      ST_CAL: begin
        if (cnt_zero) begin
          nxt_state    = ST_IDLE; // R7
          nxt_cal_done = 1'b1;
        end
      end

      // a fall wakes a sleeping core, a rise starts a conversion
      ST_IDLE: begin
        if (nxt_mode == `APMS_MODE_DOWN) begin
          nxt_state = ST_DOWN;
        end else if (strobe_fall & sleep_between & ~core_on_ff) begin
          nxt_state = ST_WAKE; // R13
          nxt_cnt   = WAKE_CYC[20:0]; // R10
        end else if (strobe_rise) begin
          nxt_state = ST_CONV;
          nxt_cnt   = CONV_CYC[20:0];
        end
      end

      // host must hold the strobe low for the wake time
      ST_WAKE: begin
        if (cnt_zero) begin
          nxt_wake_done = 1'b1;
        end
        if (strobe_rise) begin
          nxt_state     = ST_CONV;
          nxt_cnt       = CONV_CYC[20:0];
          nxt_wake_done = 1'b0;
        end
      end

      // conversion end returns to idle, which may power down, or goes straight to down under code 10
      ST_CONV: begin
        if (cnt_zero) begin
          nxt_state = (nxt_mode == `APMS_MODE_DOWN) ? ST_DOWN : ST_IDLE; // R12
        end
      end

      // strobes ignored while held down
      ST_DOWN: begin
        if (nxt_mode != `APMS_MODE_DOWN) begin
          nxt_state = ST_IDLE; // R18
        end
      end
      default: begin
        nxt_state = ST_INIT;
      end
    endcase
    nxt_busy = (nxt_state == ST_TIMEOUT) | (nxt_state == ST_CAL) |
               (nxt_state == ST_CONV);
    // run flags follow the next state so they line up with busy
    nxt_cal_run = (nxt_state == ST_CAL);
    nxt_conv    = (nxt_state == ST_CONV);
    case (nxt_state)
      // sleep pin has no effect during the power-on sequence
      ST_INIT, ST_TIMEOUT, ST_WAITCAL, ST_CAL: begin
        nxt_core = 1'b1; // R7
        nxt_ref  = 1'b1;
      end
      // awake for the wake-up and the conversion
      ST_WAKE, ST_CONV: begin
        nxt_core = 1'b1;
        nxt_ref  = 1'b1;
      end
      // full power-down
      ST_DOWN: begin
        nxt_core = 1'b0; // R2
        nxt_ref  = 1'b0;
      end
      // idle power follows the mode code and the pin
      default: begin
        nxt_core = ~sleep_between; // R12
        nxt_ref  = ~sleep_between | (nxt_mode == `APMS_MODE_PARTIAL); // R2
      end
    endcase
  end

  // every output comes straight from a flip-flop
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff       <= ST_INIT;
      mode_ff        <= `APMS_MODE_PIN;
      strobe_d_ff    <= 1'b1;
      strobe_seen_ff <= 1'b0;
      cnt_ff         <= 21'h0;
      wake_done_ff   <= 1'b0;
      busy_ff        <= 1'b0;
      core_on_ff     <= 1'b1;
      ref_on_ff      <= 1'b1;
      cal_run_ff     <= 1'b0;
      cal_done_ff    <= 1'b0;
      conv_run_ff    <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      mode_ff        <= nxt_mode;
      strobe_d_ff    <= strobe_s;
      strobe_seen_ff <= strobe_seen_ff | strobe_rise;
      cnt_ff         <= nxt_cnt;
      wake_done_ff   <= nxt_wake_done;
      busy_ff        <= nxt_busy;
      core_on_ff     <= nxt_core;
      ref_on_ff      <= nxt_ref;
      cal_run_ff     <= nxt_cal_run;
      cal_done_ff    <= nxt_cal_done;
      conv_run_ff    <= nxt_conv;
    end
  end
endmodule // apms_sequencer

// >>> tb/apms_monitor.sv
// checker for the power sequencer ports
`timescale 1ns/1ps
module apms_monitor (
  input wire ref_clk,
  input wire rstn,
  input wire conversion_start_strobe_n,
  input wire sleep_n,
  input wire ctrl_wr,
  input wire power_mode_hi_bit,
  input wire power_mode_lo_bit,
  input wire busy_ff,
  input wire core_on_ff,
  input wire ref_on_ff,
  input wire cal_run_ff,
  input wire cal_done_ff,
  input wire conv_run_ff
);
  reg [1:0] mode_ff;
  reg       seen_ff;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_ff <= 2'h0;
      seen_ff <= 1'b0;
    end else begin
      seen_ff <= seen_ff | busy_ff;
      if (ctrl_wr) mode_ff <= {power_mode_hi_bit, power_mode_lo_bit};
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_skip; ctrl_wr && !seen_ff && !busy_ff |=> cal_done_ff; endproperty
  a_skip: assert property (p_skip) else $error("no skip");
  property p_early; !cal_done_ff |-> core_on_ff; endproperty
  a_early: assert property (p_early) else $error("early sleep");
  property p_cal; cal_run_ff |-> busy_ff; endproperty
  a_cal: assert property (p_cal) else $error("cal not busy");
  property p_part; $fell(conv_run_ff) && mode_ff == 2'h3 |-> ##[0:1] ref_on_ff && !core_on_ff;
  endproperty
  a_part: assert property (p_part) else $error("bad partial");
  property p_betw; $fell(conv_run_ff) && mode_ff == 2'h1 |-> ##[0:1] !ref_on_ff && !core_on_ff;
  endproperty
  a_betw: assert property (p_betw) else $error("bad between");
  property p_down; mode_ff == 2'h2 && $past(mode_ff) == 2'h2 && cal_done_ff
    |-> !core_on_ff && !ref_on_ff && !busy_ff; endproperty
  a_down: assert property (p_down) else $error("bad down");
  property p_up; mode_ff == 2'h0 && sleep_n && $past(sleep_n, 4) && cal_done_ff |-> core_on_ff;
  endproperty
  a_up: assert property (p_up) else $error("bad up");
  property p_wake; $fell(conversion_start_strobe_n) && mode_ff != 2'h2 |-> ##[1:5] core_on_ff;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  c_cal: cover property ($fell(cal_run_ff));
  c_part: cover property ($fell(conv_run_ff) && mode_ff == 2'h3);
  c_down: cover property (mode_ff == 2'h2 && cal_done_ff);
endmodule // apms_monitor
bind apms_sequencer apms_monitor apms_monitor_i (.*);

// >>> tb/apms_host_model.sv
// host model driving the conversion strobe
`timescale 1ns/1ps
module apms_host_model (
  input  wire ref_clk,
  output reg  strobe_n
);
  initial strobe_n = 1'b1;
  // low phase must cover the wake time before the starting rise
  task pulse(input integer low_cyc);
    begin
      @(negedge ref_clk) strobe_n = 1'b0;
      repeat (low_cyc) @(negedge ref_clk);
      strobe_n = 1'b1;
    end
  endtask
endmodule // apms_host_model

// >>> tb/apms_sequencer_tb.sv
// testbench for the power-management sequencer
`timescale 1ns/1ps
module apms_sequencer_tb;
  localparam TO = 50, WK = 10, CV = 20;
  reg     ref_clk, rstn, sleep_n, ctrl_wr, power_mode_hi_bit, power_mode_lo_bit;
  wire    conversion_start_strobe_n, busy_ff, core_on_ff, ref_on_ff;
  wire    cal_run_ff, cal_done_ff, conv_run_ff;
  integer error_cnt = 0, n_compared = 0, seed = 32'h18d6f9db, i, k, n, cyc = 0;
  reg [1:0] m;
  apms_sequencer #(.TIMEOUT_CYC(TO), .WAKE_CYC(WK), .CONV_CYC(CV)) apms_sequencer_i (.*);
  apms_host_model apms_host_model_i (.ref_clk(ref_clk), .strobe_n(conversion_start_strobe_n));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      finish_test;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0t got %0h exp %0h", $time, got, exp);
      end
    end
  endtask
  task blen;
    begin
      n = 0;
      for (i = 0; i < 200 && busy_ff !== 1'b1; i = i + 1) @(negedge ref_clk);
      while (busy_ff === 1'b1 && n < 300) begin
        @(negedge ref_clk);
        n = n + 1;
      end
    end
  endtask
  task wr(input [1:0] c);
    begin
      @(negedge ref_clk) {power_mode_hi_bit, power_mode_lo_bit} = c;
      ctrl_wr = 1'b1;
      @(negedge ref_clk) ctrl_wr = 1'b0;
    end
  endtask
  // expected {reference, core} power after a conversion
  function [1:0] exp_pw(input [1:0] c, input s);
    exp_pw = (c == 2'h0 && s) ? 2'h3 : (c == 2'h3 ? 2'h2 : 2'h0);
  endfunction
  task conv(input [1:0] c);
    begin
      fork
        apms_host_model_i.pulse(WK + 2);
        blen;
        begin
          repeat (7) @(negedge ref_clk);
          chk(core_on_ff, 1);
        end
      join
      chk(n, CV + 1);
      chk({ref_on_ff, core_on_ff}, exp_pw(c, sleep_n));
    end
  endtask
  task finish_test;
    begin
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    {rstn, sleep_n, ctrl_wr, power_mode_hi_bit, power_mode_lo_bit} = 5'h00;
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    chk({ref_on_ff, core_on_ff, busy_ff, cal_done_ff}, 4'hc);
    fork
      begin
        apms_host_model_i.pulse(2);
        repeat (10) @(negedge ref_clk);
        apms_host_model_i.pulse(2);
      end
      blen;
    join
    chk(n, TO + 1);
    chk(core_on_ff, 1);
    sleep_n = 1'b1;
    fork
      apms_host_model_i.pulse(2);
      blen;
    join
    chk(n, TO + 1);
    chk(cal_done_ff, 1);
    conv(2'h0);
    sleep_n = 1'b0;
    conv(2'h0);
    for (k = 0; k < 6; k = k + 1) begin
      m = ($random(seed) & 1) ? 2'h3 : 2'h1;
      wr(m);
      sleep_n = $random(seed);
      conv(m);
    end
    wr(2'h2);
    chk({ref_on_ff, core_on_ff}, 2'h0);
    fork
      apms_host_model_i.pulse(WK + 2);
      blen;
    join
    chk(n, 0);
    sleep_n = 1'b1;
    wr(2'h0);
    @(negedge ref_clk);
    chk(core_on_ff, 1);
    conv(2'h0);
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    wr(2'h1);
    chk(cal_done_ff, 1);
    repeat (WK) @(negedge ref_clk);
    conv(2'h1);
    finish_test;
  end
endmodule // apms_sequencer_tb
